// ---- hw/sadc_top.sv ----
// Contract
// R01: with chain select low the shared pin only gates the serial output.
// R02: with chain select high the shared pin is the upstream serial input.
// R03: in normal mode the output drives while the gate is low, else floats.
// R04: a rising convert_start edge ends acquisition and starts conversion.
// R05: after conversion the core powers down while convert_start is high.
// R06: the busy output is high from conversion start until it finishes.
// R07: each serial clock rise shifts out one bit, most significant first.
// R08: the result is a 16-bit two's-complement code.
// R09: conversion is a 16-step successive approximation from half scale down.
// R10: at the end of conversion the code is loaded into the output shifter.
// R11: in chain mode upstream data follows the own result through the shifter.
// R12: conversion is timed by an internal oscillator, not by the serial clock.
// R13: the readout belongs to the conversion just finished, no latency.
// R14: the first bit shows as busy falls, before any serial clock edge.
// R15: the host waits for busy low and gives sixteen clocks per converter.
`timescale 1ns/1ns
`include "sadc_defines.svh"
module sadc_top
  import sadc_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire sadc_apb_req_t apb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  input wire logic convert_start_i,
  input wire logic chain_mode_i,
  input wire logic read_gate_or_upstream_input_i,
  input wire logic sck_i,
  input wire logic [15:0] analog_sample_i,
  output logic busy_o,
  output logic sdo_o,
  output logic sdo_oe_n_o
);
  localparam int TRIAL = `SADC_TRIAL_CYC;
  localparam int CONV_M1 = `SADC_NBITS * TRIAL - 1;

  sadc_state_t s;
  sadc_state_t next_s;
  logic setup;
  logic access;
  logic mapped;
  logic cv_rise;
  logic ck_rise;
  logic shift_en;
  logic trial_end;
  logic [15:0] trial;
  logic [1:0] ev;
  logic [1:0] clr;

  assign setup = apb_i.psel & ~apb_i.penable;
  assign access = apb_i.psel & apb_i.penable;
  assign mapped = apb_i.paddr == `SADC_OFF_STATUS ||
                  apb_i.paddr == `SADC_OFF_MASK ||
                  apb_i.paddr == `SADC_OFF_RESULT ||
                  apb_i.paddr == `SADC_OFF_STATE;
  assign cv_rise = s.cv_s2 & ~s.cv_d;
  // sck is oversampled, so only clocks slower than clk_i/2 are seen
  assign ck_rise = s.ck_s2 & ~s.ck_d;
  // outside conversion, chain mode always shifts; normal mode only while the gate is low
  assign shift_en = ck_rise && s.st != SADC_CONV &&
                    (s.ch_s2 || !s.gt_s2); // R01 R02
  assign trial_end = s.tick == 2'(TRIAL - 1);
  assign trial = s.code | 16'(16'h0001 << s.bitn);

  always_comb begin
    next_s = s;
    ev = 2'h0;
    clr = 2'h0;
    next_s.cv_s1 = convert_start_i;
    next_s.cv_s2 = s.cv_s1;
    next_s.cv_d = s.cv_s2;
    next_s.ck_s1 = sck_i;
    next_s.ck_s2 = s.ck_s1;
    next_s.ck_d = s.ck_s2;
    next_s.gt_s1 = read_gate_or_upstream_input_i;
    next_s.gt_s2 = s.gt_s1;
    next_s.ch_s1 = chain_mode_i;
    next_s.ch_s2 = s.ch_s1;
    next_s.smp_s1 = analog_sample_i;
    next_s.smp_s2 = s.smp_s1;
    case (s.st)
      SADC_ACQ: begin
        if (cv_rise) begin // R04
          next_s.st = SADC_CONV; // R06
          // offset binary makes the trial compare unsigned
          next_s.hold = s.smp_s2 ^ `SADC_MSB_FLIP;
          next_s.code = `SADC_CODE_RST;
          next_s.bitn = 4'(`SADC_NBITS - 1);
          next_s.tick = 2'h0;
        end
      end
      SADC_CONV: begin
        // internal oscillator: a fixed count of clk_i per trial
        next_s.tick = trial_end ? 2'h0 : s.tick + 2'h1; // R12
        if (trial_end) begin
          if (trial <= s.hold) begin // R09
            next_s.code = trial;
          end
          next_s.bitn = s.bitn - 4'h1;
          if (s.bitn == 4'h0) begin
            next_s.result = (trial <= s.hold ? trial : s.code) ^
                            `SADC_MSB_FLIP; // R08 R13
            next_s.shreg = next_s.result; // R10 R14
            next_s.shcnt = 5'h00;
            ev[`SADC_STS_DONE] = 1'b1;
            next_s.st = s.cv_s2 ? SADC_PDN : SADC_ACQ; // R05
          end
        end
      end
      SADC_PDN: begin
        if (!s.cv_s2) begin // R05
          next_s.st = SADC_ACQ;
        end
      end
      default: begin
        next_s.st = SADC_ACQ;
      end
    endcase
    if (shift_en) begin
      // gate pin doubles as upstream data in chain mode
      next_s.shreg = {s.shreg[14:0],
                      s.ch_s2 & s.gt_s2}; // R07 R11
      if (s.shcnt != `SADC_READ_LEN) begin
        next_s.shcnt = s.shcnt + 5'h01;
        if (s.shcnt == `SADC_READ_LEN - 5'h01) begin
          ev[`SADC_STS_READ] = 1'b1;
        end
      end
    end
    if (setup) begin
      case (apb_i.paddr)
        `SADC_OFF_STATUS: next_s.rdata = {30'h0, s.sts};
        `SADC_OFF_MASK: next_s.rdata = {30'h0, s.mask};
        `SADC_OFF_RESULT: next_s.rdata = {16'h0, s.result};
        `SADC_OFF_STATE: next_s.rdata = {27'h0, s.ch_s2,
                                         s.shcnt == `SADC_READ_LEN, s.st};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    if (access && apb_i.pwrite) begin
      if (apb_i.paddr == `SADC_OFF_STATUS) begin
        clr = apb_i.pwdata[1:0];
      end
      if (apb_i.paddr == `SADC_OFF_MASK) begin
        next_s.mask = apb_i.pwdata[1:0];
      end
    end
    // a set in the clearing cycle survives
    next_s.sts = (s.sts & ~clr) | ev;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
      s.st <= SADC_ACQ;
      s.sts <= `SADC_STS_RST;
      s.mask <= `SADC_MASK_RST;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign prdata_o = s.rdata;
  assign pready_o = access;
  assign pslverr_o = access & ~mapped;
  assign irq_o = |(s.sts & s.mask);
  assign busy_o = s.st == SADC_CONV; // R06
  assign sdo_o = s.shreg[15]; // R07 R14
  assign sdo_oe_n_o = s.ch_s2 ? 1'b0 : s.gt_s2; // R03

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i || !ce_i);

  property p_start;
    cv_rise && s.st == SADC_ACQ |=> busy_o;
  endproperty
  a_start: assert property (p_start) // R04
    else $error("conversion did not start on convert edge");

  property p_conv_len;
    $rose(busy_o) |-> ##CONV_M1 busy_o ##1 !busy_o;
  endproperty
  a_conv_len: assert property (p_conv_len) // R12
    else $error("conversion length wrong");

  property p_sar;
    $fell(busy_o) |-> s.result == ($past(s.hold) ^ `SADC_MSB_FLIP);
  endproperty
  a_sar: assert property (p_sar) // R09
    else $error("result differs from sampled value");

  property p_load;
    $fell(busy_o) |-> s.shreg == s.result && sdo_o == s.result[15];
  endproperty
  a_load: assert property (p_load) // R14
    else $error("result not loaded when busy fell");

  property p_pdn_hold;
    s.st == SADC_PDN && s.cv_s2 |=> s.st == SADC_PDN;
  endproperty
  a_pdn_hold: assert property (p_pdn_hold) // R05
    else $error("left power down while convert high");

  property p_pdn_exit;
    s.st == SADC_PDN && !s.cv_s2 |=> s.st == SADC_ACQ;
  endproperty
  a_pdn_exit: assert property (p_pdn_exit) // R05
    else $error("did not power up on convert low");

  property p_shift;
    shift_en |=> s.shreg[15:1] == $past(s.shreg[14:0]);
  endproperty
  a_shift: assert property (p_shift) // R07
    else $error("serial shift wrong");

  property p_chain_in;
    shift_en && s.ch_s2 |=> s.shreg[0] == $past(s.gt_s2);
  endproperty
  a_chain_in: assert property (p_chain_in) // R11
    else $error("upstream bit not taken");

  property p_gated;
    ck_rise && !s.ch_s2 && s.gt_s2 |=> $stable(s.shreg);
  endproperty
  a_gated: assert property (p_gated) // R01
    else $error("shift while gate high");

  property p_oe;
    s.ch_s2 ? !sdo_oe_n_o : sdo_oe_n_o == s.gt_s2;
  endproperty
  a_oe: assert property (p_oe) // R03
    else $error("output enable wrong");

  property p_done_flag;
    $fell(busy_o) |-> s.sts[`SADC_STS_DONE];
  endproperty
  a_done_flag: assert property (p_done_flag) // R10
    else $error("done flag not set");

  property p_acq_idle;
    s.st == SADC_ACQ && !cv_rise |=> !busy_o;
  endproperty
  a_acq_idle: assert property (p_acq_idle) // R04
    else $error("conversion started without convert edge");

  property p_pdn_no_start;
    s.st == SADC_PDN |=> !busy_o;
  endproperty
  a_pdn_no_start: assert property (p_pdn_no_start) // R05
    else $error("conversion started from power down");

  property p_sar_init;
    $rose(busy_o) |-> s.code == `SADC_CODE_RST &&
                      s.bitn == 4'(`SADC_NBITS - 1);
  endproperty
  a_sar_init: assert property (p_sar_init) // R09
    else $error("approximation did not start at half scale");

  property p_sar_keep;
    busy_o && trial_end && trial > s.hold |=> s.code == $past(s.code);
  endproperty
  a_sar_keep: assert property (p_sar_keep) // R09
    else $error("trial bit kept although above sample");

  property p_sar_set;
    busy_o && trial_end && trial <= s.hold |=> s.code == $past(trial);
  endproperty
  a_sar_set: assert property (p_sar_set) // R09
    else $error("trial bit dropped although not above sample");

  property p_osc_pace;
    busy_o && !trial_end |=> $stable(s.bitn) && $stable(s.code);
  endproperty
  a_osc_pace: assert property (p_osc_pace) // R12
    else $error("approximation moved between oscillator ticks");

  property p_conv_quiet;
    busy_o && !(trial_end && s.bitn == 4'h0) |=> $stable(s.shreg);
  endproperty
  a_conv_quiet: assert property (p_conv_quiet) // R12
    else $error("shifter disturbed during conversion");

  property p_hold_keep;
    busy_o |=> $stable(s.hold);
  endproperty
  a_hold_keep: assert property (p_hold_keep) // R13
    else $error("held sample changed during conversion");

  property p_result_keep;
    !$fell(busy_o) |-> $stable(s.result);
  endproperty
  a_result_keep: assert property (p_result_keep) // R13
    else $error("result changed outside conversion end");

  property p_normal_fill;
    shift_en && !s.ch_s2 |=> !s.shreg[0];
  endproperty
  a_normal_fill: assert property (p_normal_fill) // R01
    else $error("normal mode shifted in pin data");

  property p_read_flag;
    shift_en && s.shcnt == `SADC_READ_LEN - 5'h01 |=> s.sts[`SADC_STS_READ];
  endproperty
  a_read_flag: assert property (p_read_flag) // R15
    else $error("readout flag not set after sixteenth shift");
endmodule

// ---- hw/sadc_defines.svh ----
`ifndef SADC_DEFINES_SVH
`define SADC_DEFINES_SVH
`define SADC_NBITS 16
`define SADC_OFF_STATUS 12'h000
`define SADC_OFF_MASK 12'h004
`define SADC_OFF_RESULT 12'h008
`define SADC_OFF_STATE 12'h00C
`define SADC_STS_DONE 0
`define SADC_STS_READ 1
`define SADC_STS_RST 2'h0
`define SADC_MASK_RST 2'h0
`define SADC_CODE_RST 16'h0000
`define SADC_MSB_FLIP 16'h8000
`define SADC_CLK_NS 10
`define SADC_OSC_PERIOD_NS 40
`define SADC_TRIAL_CYC \
  ((`SADC_OSC_PERIOD_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_READ_LEN 5'h10
`endif

// ---- hw/sadc_pkg.sv ----
package sadc_pkg;
  typedef enum logic [2:0] {
    SADC_ACQ = 3'b001,
    SADC_CONV = 3'b010,
    SADC_PDN = 3'b100
  } sadc_st_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } sadc_apb_req_t;

  typedef struct packed {
    logic cv_s1;
    logic cv_s2;
    logic cv_d;
    logic ck_s1;
    logic ck_s2;
    logic ck_d;
    logic gt_s1;
    logic gt_s2;
    logic ch_s1;
    logic ch_s2;
    logic [15:0] smp_s1;
    logic [15:0] smp_s2;
    sadc_st_t st;
    logic [1:0] tick;
    logic [3:0] bitn;
    logic [15:0] hold;
    logic [15:0] code;
    logic [15:0] result;
    logic [15:0] shreg;
    logic [4:0] shcnt;
    logic [1:0] sts;
    logic [1:0] mask;
    logic [31:0] rdata;
  } sadc_state_t;
endpackage

// ---- verification/sadc_host_model.sv ----
`timescale 1ns/1ns
module sadc_host_model (
  input wire logic clk_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_n_i,
  output logic convert_start_o,
  output logic sck_o,
  output logic gate_o
);
  initial begin
    convert_start_o = 1'b0;
    sck_o = 1'b0;
    gate_o = 1'b1;
  end
  task automatic set_convert(input logic v);
    @(posedge clk_i);
    convert_start_o <= v;
  endtask
  task automatic set_gate(input logic v);
    @(posedge clk_i);
    gate_o <= v;
  endtask
  // data set up three cycles ahead of the rise so both syncs agree
  // a released line reads inverted, so a missing enable shows as a miss
  task automatic shift(input logic din, output logic dout);
    @(posedge clk_i);
    gate_o <= din;
    repeat (3) @(posedge clk_i);
    dout = sdo_oe_n_i ? !sdo_i : sdo_i;
    sck_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    sck_o <= 1'b0;
  endtask
endmodule

// ---- verification/sar_adc_serial_readout_tb.sv ----
`timescale 1ns/1ns
`include "sadc_defines.svh"
module sar_adc_serial_readout_tb
  import sadc_pkg::*;
;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic chain_mode_i = 1'b0;
  logic [15:0] analog_sample_i = 16'h0000;
  sadc_apb_req_t apb_i = '0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, irq_o, busy_o, sdo_o, sdo_oe_n_o;
  logic convert_start, sck, gate;
  int n_fail = 0;
  int checks = 0;
  always #5 clk_i = ~clk_i;
  sadc_top u_sadc_top (
    .clk_i, .nrst_i, .ce_i(1'b1), .apb_i, .prdata_o, .pready_o,
    .pslverr_o, .irq_o, .convert_start_i(convert_start), .chain_mode_i,
    .read_gate_or_upstream_input_i(gate), .sck_i(sck),
    .analog_sample_i, .busy_o, .sdo_o, .sdo_oe_n_o
  );
  sadc_host_model u_sadc_host_model (
    .clk_i, .sdo_i(sdo_o), .sdo_oe_n_i(sdo_oe_n_o),
    .convert_start_o(convert_start), .sck_o(sck), .gate_o(gate)
  );
  task automatic test_done();
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  // zero wait states expected; only the watchdog ends a missing answer
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clk_i);
    apb_i <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_i);
    apb_i.penable <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) begin
      @(posedge clk_i);
    end
    r = prdata_o;
    e = pslverr_o;
    apb_i.psel <= 1'b0;
    apb_i.penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp,
      input logic [31:0] m = 32'hFFFFFFFF);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, exp);
    chk(e, 1'b0);
  endtask
  initial begin
    #100000;
    n_fail++;
    test_done();
  end
  initial begin
    logic [31:0] r, w;
    logic e, b;
    logic [15:0] s, u;
    logic q[$];
    int n;
    void'($urandom(32'hE6B8));
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rchk(`SADC_OFF_STATUS, 32'h0);
    rchk(`SADC_OFF_MASK, 32'h0);
    rchk(`SADC_OFF_STATE, 32'h1, 32'h17);
    apb(1'b0, 12'h010, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    apb(1'b1, `SADC_OFF_MASK, 32'h2, r, e);
    rchk(`SADC_OFF_MASK, 32'h2);
    for (int i = 0; i < 6; i++) begin
      s = 16'($urandom);
      u = 16'($urandom);
      w = {s, u};
      analog_sample_i <= s;
      chain_mode_i <= i[0];
      repeat (4) @(posedge clk_i);
      u_sadc_host_model.set_convert(1'b1);
      n = 0;
      while (busy_o !== 1'b1 && n < 20) begin
        @(posedge clk_i);
        n++;
      end
      n = 0;
      while (busy_o === 1'b1 && n < 100) begin
        @(posedge clk_i);
        n++;
      end
      chk(n, `SADC_NBITS * `SADC_TRIAL_CYC);
      chk(sdo_o, s[15]);
      rchk(`SADC_OFF_RESULT, {16'h0000, s});
      rchk(`SADC_OFF_STATE, {27'h0, i[0], 4'h4}, 32'h17);
      chk(irq_o, 1'b0);
      rchk(`SADC_OFF_STATUS, 32'h1);
      u_sadc_host_model.set_convert(1'b0);
      repeat (6) @(posedge clk_i);
      rchk(`SADC_OFF_STATE, {27'h0, i[0], 4'h1}, 32'h17);
      n = i[0] ? 32 : 16;
      q = {};
      for (int k = 0; k < n; k++) q.push_back(w[31 - k]);
      for (int k = 0; k < n; k++) begin
        u_sadc_host_model.shift(i[0] && k < 16 && u[15 - k], b);
        chk(b, q.pop_front());
      end
      chk(sdo_oe_n_o, 1'b0);
      u_sadc_host_model.set_gate(1'b1);
      repeat (5) @(posedge clk_i);
      chk(sdo_oe_n_o, !i[0]);
      rchk(`SADC_OFF_STATUS, 32'h3);
      chk(irq_o, 1'b1);
      apb(1'b1, `SADC_OFF_STATUS, 32'h3, r, e);
      rchk(`SADC_OFF_STATUS, 32'h0);
      chk(irq_o, 1'b0);
    end
    test_done();
  end
endmodule
